// ===== srm_defines.svh
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH
// register byte offsets
`define SRM_OFF_CMD       12'h000
`define SRM_OFF_NSSEL     12'h004
`define SRM_OFF_ARG       12'h008
`define SRM_OFF_STATUS    12'h00c
`define SRM_OFF_CPL0      12'h010
`define SRM_OFF_POOL      12'h014
`define SRM_OFF_ALLOC     12'h018
`define SRM_OFF_IRQ_STAT  12'h01c
`define SRM_OFF_IRQ_MASK  12'h020
`define SRM_OFF_OPEN      12'h024
`define SRM_OFF_DATA      12'h100
// command register fields
`define SRM_CMD_GO_BIT    8
`define SRM_CMD_SEND_BIT  9
// operation codes
`define SRM_OP_RELEASE_ID 8'h01
`define SRM_OP_GET_STATUS 8'h02
`define SRM_OP_RELEASE_RS 8'h02
`define SRM_OP_ALLOCATE   8'h03
// namespace selector meaning all namespaces
`define SRM_NS_ALL        32'hffffffff
// completion status codes
`define SRM_ST_SUCCESS    8'h00
`define SRM_ST_INVALID    8'h02
`define SRM_ST_ALLOC_FAIL 8'h7f
// sizes
`define SRM_NUM_NS        4
`define SRM_NUM_SLOTS     8
`define SRM_POOL_RESET    16'h0008
// interrupt bits
`define SRM_IRQ_DONE_BIT  0
`define SRM_IRQ_ERR_BIT   1
`endif

// ===== srm_pkg.sv
package srm_pkg;
    typedef enum logic [1:0] {
        SRM_IDLE = 2'b00,
        SRM_EXEC = 2'b01,
        SRM_SCAN = 2'b10
    } srm_state_type;
endpackage

// ===== srm_stream_manager.sv
// Operation
// - status query returns open streams of namespace; directive field ignored
// - all-namespaces query reports streams open on the shared pool
// - status structure bytes 1:0 carry the open stream count
// - identifiers follow from byte 2 in strictly ascending order
// - granted count in low 16 bits of completion word, never above request
// - granted count is kept as the namespace allocated field
// - nothing grantable: fail status, or grant zero when shared pool remains
// - allocation on namespace already holding resources: invalid field, no change
// - allocate and both releases move no data, only completion
// - grant is held per namespace, usable by every controller of host
// - identifier release closes the named stream
// - releasing a stream that is not open still succeeds
// - closed stream resource stays with namespace if exclusive, else to pool
// - identifier release on all-namespaces selector gets invalid field
// - full release frees namespace grant and sets allocated count to zero
// - full release with no grant succeeds
`timescale 1ns/1ns
`include "srm_defines.svh"
module srm_stream_manager (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // stream open from the write path
    input wire logic open_i,
    input wire logic [31:0] open_ns_i,
    input wire logic [15:0] open_id_i,
    // interrupt
    output logic irq_o
);
    localparam int NS = `SRM_NUM_NS;
    localparam int SL = `SRM_NUM_SLOTS;

    // address phase capture
    logic wr_pend;
    logic [11:0] a_addr;
    wire addr_ok = hsel_i && hready_i && htrans_i[1];
    wire [11:0] da = a_addr;
    wire w_cmd = wr_pend && (da == `SRM_OFF_CMD);
    wire w_ns = wr_pend && (da == `SRM_OFF_NSSEL);
    wire w_arg = wr_pend && (da == `SRM_OFF_ARG);
    wire w_pool = wr_pend && (da == `SRM_OFF_POOL);
    wire w_ista = wr_pend && (da == `SRM_OFF_IRQ_STAT);
    wire w_imsk = wr_pend && (da == `SRM_OFF_IRQ_MASK);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend <= 1'b0;
            a_addr <= 12'h000;
        end else begin
            wr_pend <= addr_ok && hwrite_i;
            if (addr_ok) begin
                a_addr <= haddr_i[11:0];
            end
        end
    end

    // software visible state
    logic [9:0] cmd;
    logic [31:0] nssel;
    logic [31:0] arg;
    logic [7:0] status;
    logic [31:0] cpl0;
    logic [15:0] pool;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [15:0] alloc [NS];
    // open stream table: valid, identifier, namespace index, exclusive, on shared pool
    logic [SL-1:0] s_val;
    logic [SL-1:0] s_all;
    logic [15:0] s_id [SL];
    logic [1:0] s_ns [SL];
    // status structure image
    logic [15:0] st_cnt;
    logic [15:0] st_ent [SL];

    srm_pkg::srm_state_type state;
    srm_pkg::srm_state_type next_state;
    logic [15:0] last_id;
    logic first_pick;

    wire is_all = (nssel == `SRM_NS_ALL);
    wire [1:0] nsi = nssel[1:0];
    wire ns_ok = is_all || (nssel < 32'(NS));
    wire [7:0] op = cmd[7:0];
    wire is_send = cmd[`SRM_CMD_SEND_BIT];
    wire [15:0] req = arg[15:0];
    wire [15:0] cur_alloc = alloc[nsi];
    wire [15:0] rel_id = arg[15:0];

    // stream membership for current selector
    logic [SL-1:0] in_ns;
    logic [SL-1:0] hit_rel;
    logic [SL-1:0] cand;
    logic [SL-1:0] first_free;
    genvar g;
    generate
        for (g = 0; g < SL; g++) begin : g_slot
            // a namespace query lists its streams whatever pool they draw on
            assign in_ns[g] = s_val[g] && (is_all ? s_all[g] : (s_ns[g] == nsi));
            assign hit_rel[g] = in_ns[g] && (s_id[g] == rel_id);
            assign cand[g] = in_ns[g] && (first_pick || s_id[g] > last_id);
        end
    endgenerate

    // lowest candidate identifier, and first free slot
    logic [15:0] min_id;
    logic min_hit;
    always_comb begin
        min_id = 16'hffff;
        min_hit = 1'b0;
        first_free = '0;
        for (int i = 0; i < SL; i++) begin
            if (cand[i] && (!min_hit || s_id[i] < min_id)) begin
                min_id = s_id[i];
                min_hit = 1'b1;
            end
        end
        // downward walk, so the lowest free slot is the one left set
        for (int i = SL - 1; i >= 0; i--) begin
            if (!s_val[i]) begin
                first_free = '0;
                first_free[i] = 1'b1;
            end
        end
    end

    // returned-to-pool count on identifier release
    logic [15:0] back;
    always_comb begin
        back = 16'h0000;
        for (int i = 0; i < SL; i++) begin
            if (hit_rel[i] && s_all[i]) begin
                back = back + 16'h0001;
            end
        end
    end

    // an open in a namespace without a grant draws on the shared pool
    wire open_all = (open_ns_i == `SRM_NS_ALL) || (alloc[open_ns_i[1:0]] == 16'h0000);
    wire open_take = open_i && (|first_free) && (open_all ? (pool != 16'h0000) : 1'b1);
    // a pool open in a command's cycle is taken first, so neither update is lost
    wire [15:0] pool_dec = (open_take && open_all) ? 16'h0001 : 16'h0000;
    wire [15:0] avail = pool - pool_dec;
    wire [15:0] grant = (req < avail) ? req : avail;
    wire exec = (state == srm_pkg::SRM_EXEC);
    wire do_getst = exec && !is_send && (op == `SRM_OP_GET_STATUS) && ns_ok;
    wire do_alloc = exec && !is_send && (op == `SRM_OP_ALLOCATE) && ns_ok && !is_all && (cur_alloc == 16'h0000);
    wire do_relid = exec && is_send && (op == `SRM_OP_RELEASE_ID) && ns_ok && !is_all;
    wire do_relrs = exec && is_send && (op == `SRM_OP_RELEASE_RS) && ns_ok && !is_all;
    wire scan_done = (state == srm_pkg::SRM_SCAN) && !min_hit;
    // a refused command still completes, with the invalid status
    wire finish = (exec && !do_getst) || scan_done;

    logic [7:0] next_status;
    logic [31:0] next_cpl0;
    always_comb begin
        next_status = `SRM_ST_INVALID;
        next_cpl0 = 32'h00000000;
        if (do_alloc) begin
            if (grant == 16'h0000 && avail == 16'h0000) begin
                next_status = `SRM_ST_ALLOC_FAIL;
            end else begin
                next_status = `SRM_ST_SUCCESS;
                next_cpl0 = {16'h0000, grant};
            end
        end else if (do_relid || do_relrs || scan_done) begin
            next_status = `SRM_ST_SUCCESS;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            srm_pkg::SRM_IDLE: begin
                if (w_cmd && hwdata_i[`SRM_CMD_GO_BIT]) begin
                    next_state = srm_pkg::SRM_EXEC;
                end
            end
            srm_pkg::SRM_EXEC: begin
                next_state = do_getst ? srm_pkg::SRM_SCAN : srm_pkg::SRM_IDLE;
            end
            srm_pkg::SRM_SCAN: begin
                if (!min_hit) begin
                    next_state = srm_pkg::SRM_IDLE;
                end
            end
            default: begin
                next_state = srm_pkg::SRM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= srm_pkg::SRM_IDLE;
            cmd <= 10'h000;
            nssel <= 32'h00000000;
            arg <= 32'h00000000;
            status <= 8'h00;
            cpl0 <= 32'h00000000;
            irq_mask <= 2'b00;
        end else begin
            state <= next_state;
            // command registers frozen while busy, so a scan sees a stable selector
            if (w_cmd && state == srm_pkg::SRM_IDLE) begin
                cmd <= hwdata_i[9:0];
            end
            if (w_ns && state == srm_pkg::SRM_IDLE) begin
                nssel <= hwdata_i;
            end
            if (w_arg && state == srm_pkg::SRM_IDLE) begin
                arg <= hwdata_i;
            end
            if (finish) begin
                status <= next_status;
                cpl0 <= next_cpl0;
            end
            if (w_imsk) begin
                irq_mask <= hwdata_i[1:0];
            end
        end
    end

    // interrupt status: hardware set wins over write-one-clear
    wire [1:0] irq_set = {finish && (next_status != `SRM_ST_SUCCESS), finish};
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= 2'b00;
        end else begin
            irq_stat <= (irq_stat & ~(w_ista ? hwdata_i[1:0] : 2'b00)) | irq_set;
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // shared pool and per-namespace grants; grant keyed by namespace only, so every
    // controller of the host sees it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pool <= `SRM_POOL_RESET;
            for (int i = 0; i < NS; i++) begin
                alloc[i] <= 16'h0000;
            end
        end else begin
            if (w_pool && state == srm_pkg::SRM_IDLE) begin
                pool <= hwdata_i[15:0];
            end else if (do_alloc) begin
                pool <= avail - grant;
                alloc[nsi] <= grant;
            end else if (do_relrs) begin
                pool <= avail + cur_alloc;
                alloc[nsi] <= 16'h0000;
            end else if (do_relid) begin
                pool <= avail + back;
            end else begin
                pool <= avail;
            end
        end
    end

    // open stream table
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_val <= '0;
            s_all <= '0;
            for (int i = 0; i < SL; i++) begin
                s_id[i] <= 16'h0000;
                s_ns[i] <= 2'b00;
            end
        end else begin
            for (int i = 0; i < SL; i++) begin
                if (do_relid && hit_rel[i]) begin
                    s_val[i] <= 1'b0;
                end else if (open_take && first_free[i]) begin
                    s_val[i] <= 1'b1;
                    s_all[i] <= open_all;
                    s_id[i] <= open_id_i;
                    s_ns[i] <= open_ns_i[1:0];
                end
            end
        end
    end

    // status structure build: one identifier per cycle, ascending
    // last_id only orders picks within one scan; first_pick restarts each query
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_cnt <= 16'h0000;
            last_id <= 16'h0000;
            first_pick <= 1'b1;
            for (int i = 0; i < SL; i++) begin
                st_ent[i] <= 16'h0000;
            end
        end else if (do_getst) begin
            st_cnt <= 16'h0000;
            first_pick <= 1'b1;
            for (int i = 0; i < SL; i++) begin
                st_ent[i] <= 16'h0000;
            end
        end else if (state == srm_pkg::SRM_SCAN && min_hit) begin
            st_ent[st_cnt[2:0]] <= min_id;
            st_cnt <= st_cnt + 16'h0001;
            last_id <= min_id;
            first_pick <= 1'b0;
        end
    end

    // read mux, decoded in the address phase and registered for the data phase;
    // a read overlapping the data phase of a write to the same register sees the old value
    wire [11:0] ra = haddr_i[11:0];
    wire rd_take = addr_ok && !hwrite_i;
    // data window word k holds bytes 4k+3..4k of the status structure
    wire [11:0] doff = ra - `SRM_OFF_DATA;
    wire in_data = (ra >= `SRM_OFF_DATA) && (doff < 12'(SL * 2 + 2));
    wire [3:0] wk = doff[5:2];
    wire [15:0] lo_half = (wk == 4'h0) ? st_cnt : st_ent[3'(2 * wk - 1)];
    wire [15:0] hi_half = (wk == 4'(SL / 2)) ? 16'h0000 : st_ent[3'(2 * wk)];
    logic [31:0] rmux;
    always_comb begin
        if (ra == `SRM_OFF_CMD) begin
            rmux = {21'h000000, state != srm_pkg::SRM_IDLE, cmd};
        end else if (ra == `SRM_OFF_NSSEL) begin
            rmux = nssel;
        end else if (ra == `SRM_OFF_ARG) begin
            rmux = arg;
        end else if (ra == `SRM_OFF_STATUS) begin
            rmux = {24'h000000, status};
        end else if (ra == `SRM_OFF_CPL0) begin
            rmux = cpl0;
        end else if (ra == `SRM_OFF_POOL) begin
            rmux = {16'h0000, pool};
        end else if (ra == `SRM_OFF_ALLOC) begin
            rmux = {16'h0000, alloc[nsi]};
        end else if (ra == `SRM_OFF_IRQ_STAT) begin
            rmux = {30'h00000000, irq_stat};
        end else if (ra == `SRM_OFF_IRQ_MASK) begin
            rmux = {30'h00000000, irq_mask};
        end else if (ra == `SRM_OFF_OPEN) begin
            rmux = {24'h000000, s_val};
        end else if (in_data) begin
            rmux = {hi_half, lo_half};
        end else begin
            rmux = 32'h00000000;
        end
    end
    logic [31:0] rdata;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd_take ? rmux : 32'h00000000;
        end
    end
    assign hrdata_o = rdata;
    // zero wait states, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
endmodule

// ===== srm_stream_manager_sva.sv
`timescale 1ns/1ns
`include "srm_defines.svh"
module srm_stream_manager_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    logic rd_q, wr_q;
    logic [11:0] a_q;
    logic [31:0] ns_q, arg_q;
    logic [9:0] op_q;
    wire take = hsel_i && hready_i && htrans_i[1];
    wire ns_ok = ns_q < `SRM_NUM_NS;
    // shadow of the last command, so completions are judged from the bus alone
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {rd_q, wr_q, a_q, ns_q, arg_q, op_q} <= '0;
        end else begin
            rd_q <= take && !hwrite_i;
            wr_q <= take && hwrite_i;
            a_q <= take ? haddr_i[11:0] : a_q;
            if (wr_q && a_q == `SRM_OFF_NSSEL) ns_q <= hwdata_i;
            if (wr_q && a_q == `SRM_OFF_ARG) arg_q <= hwdata_i;
            if (wr_q && a_q == `SRM_OFF_CMD && hwdata_i[`SRM_CMD_GO_BIT]) op_q <= hwdata_i[9:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_rd_status;
        rd_q && a_q == `SRM_OFF_STATUS;
    endsequence
    sequence s_rd_cpl0;
        rd_q && a_q == `SRM_OFF_CPL0;
    endsequence
    AST_BUS_OKAY: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
        else $error("bus answer not zero-wait okay");
    AST_QUIET_RDATA: assert property (!rd_q |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
    AST_RELID_ALL: assert property (s_rd_status ##0 (op_q == 10'h301 && ns_q == `SRM_NS_ALL)
        |-> hrdata_o[7:0] == `SRM_ST_INVALID) else $error("release on all selector not refused");
    AST_RELID_OK: assert property (s_rd_status ##0 (op_q == 10'h301 && ns_ok)
        |-> hrdata_o[7:0] == `SRM_ST_SUCCESS) else $error("identifier release not successful");
    AST_RELRS_OK: assert property (s_rd_status ##0 (op_q == 10'h302 && ns_ok)
        |-> hrdata_o[7:0] == `SRM_ST_SUCCESS) else $error("full release not successful");
    AST_STATUS_CODE: assert property (s_rd_status |-> hrdata_o[7:0] inside {8'h00, 8'h02, 8'h7f})
        else $error("unknown status code");
    AST_GRANT_CAP: assert property (s_rd_cpl0 ##0 op_q == 10'h103 |-> hrdata_o[15:0] <= arg_q[15:0])
        else $error("grant above request");
    AST_COUNT_CAP: assert property (rd_q && a_q == `SRM_OFF_DATA |-> hrdata_o[15:0] <= `SRM_NUM_SLOTS)
        else $error("open count above slot count");
endmodule
bind srm_stream_manager srm_stream_manager_sva chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
);

// ===== srm_host_model.sv
`timescale 1ns/1ns
module srm_host_model (
    // clock
    input wire logic clk_i,
    // ahb-lite master
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    int n_hangs = 0;
    initial begin
        hsel_o = 1'b1;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'b010;
        hwdata_o = 32'h0;
    end
    // bounded so a stuck slave ends in a report, not a hang
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready_i !== 1'b1 && n < 32);
        if (hready_i !== 1'b1) n_hangs++;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr_o <= a;
        hwrite_o <= w;
        htrans_o <= 2'b10;
        wait_ready();
        htrans_o <= 2'b00;
        // reads leave junk on the write lines
        hwdata_o <= w ? d : ~hwdata_o;
        wait_ready();
        q = hrdata_i;
    endtask
endmodule

// ===== srm_stream_manager_tb.sv
`timescale 1ns/1ns
`include "srm_defines.svh"
module srm_stream_manager_tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic open_i = 1'b0;
    logic [31:0] open_ns_i = 32'h0;
    logic [15:0] open_id_i = 16'h0;
    logic hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rv;
    int failures = 0;
    int n_tests = 0;
    always #25 clk_i = ~clk_i;
    srm_stream_manager uut (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .open_i(open_i),
        .open_ns_i(open_ns_i), .open_id_i(open_id_i), .irq_o(irq_o)
    );
    srm_host_model host (
        .clk_i(clk_i), .hready_i(hreadyout_o), .hrdata_i(hrdata_o), .hsel_o(hsel_i), .haddr_o(haddr_i),
        .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i), .hwdata_o(hwdata_i)
    );
    task automatic stop_test();
        failures += host.n_hangs;
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host.xfer(1'b0, {20'h0, a}, 32'h0, rv);
        chk($sformatf("register %h", a), exp, rv);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, {20'h0, a}, d, rv);
    endtask
    // selector, argument, go; busy is polled with a bound, then status checked
    task automatic run(input logic [31:0] ns, input logic [15:0] arg, input logic snd, input logic [7:0] op,
                       input logic [7:0] exp);
        int n;
        n = 0;
        wr(`SRM_OFF_NSSEL, ns);
        wr(`SRM_OFF_ARG, {16'h0, arg});
        wr(`SRM_OFF_CMD, {22'h0, snd, 1'b1, op});
        rv = 32'h400;
        while (rv[10] !== 1'b0 && n < 64) begin
            host.xfer(1'b0, {20'h0, `SRM_OFF_CMD}, 32'h0, rv);
            n++;
        end
        if (rv[10] !== 1'b0) begin
            $display("ERROR busy expected 0 seen 1");
            failures++;
            stop_test();
        end else begin
            rd(`SRM_OFF_STATUS, {24'h0, exp});
        end
    endtask
    task automatic open_stream(input logic [31:0] ns, input logic [15:0] id);
        open_i <= 1'b1;
        open_ns_i <= ns;
        open_id_i <= id;
        @(posedge clk_i);
        open_i <= 1'b0;
        open_id_i <= ~id;
        @(posedge clk_i);
    endtask
    task automatic t_status();
        rd(`SRM_OFF_POOL, 32'h8);
        rd(`SRM_OFF_ALLOC, 32'h0);
        rd(12'h200, 32'h0);
        open_stream(32'h1, 16'h5);
        open_stream(32'h1, 16'h2);
        open_stream(32'h1, 16'h9);
        run(32'h1, 16'hffff, 1'b0, `SRM_OP_GET_STATUS, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_DATA, 32'h0002_0003);
        rd(`SRM_OFF_DATA + 12'h4, 32'h0009_0005);
        rd(`SRM_OFF_DATA + 12'h8, 32'h0);
        run(`SRM_NS_ALL, 16'h0, 1'b0, `SRM_OP_GET_STATUS, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_DATA, 32'h0002_0003);
        rd(`SRM_OFF_POOL, 32'h5);
    endtask
    task automatic t_release_id();
        run(32'h1, 16'h5, 1'b1, `SRM_OP_RELEASE_ID, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_POOL, 32'h6);
        run(32'h1, 16'h7, 1'b1, `SRM_OP_RELEASE_ID, `SRM_ST_SUCCESS);
        run(`SRM_NS_ALL, 16'h9, 1'b1, `SRM_OP_RELEASE_ID, `SRM_ST_INVALID);
        run(32'h1, 16'h0, 1'b0, `SRM_OP_GET_STATUS, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_DATA, 32'h0002_0002);
        rd(`SRM_OFF_DATA + 12'h4, 32'h0000_0009);
    endtask
    task automatic t_allocate();
        run(32'h0, 16'h3, 1'b0, `SRM_OP_ALLOCATE, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_CPL0, 32'h3);
        rd(`SRM_OFF_ALLOC, 32'h3);
        open_stream(32'h0, 16'h4);
        run(32'h0, 16'h4, 1'b1, `SRM_OP_RELEASE_ID, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_POOL, 32'h3);
        run(32'h0, 16'h5, 1'b0, `SRM_OP_ALLOCATE, `SRM_ST_INVALID);
        rd(`SRM_OFF_ALLOC, 32'h3);
    endtask
    task automatic t_release_all();
        run(32'h0, 16'h0, 1'b1, `SRM_OP_RELEASE_RS, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_ALLOC, 32'h0);
        rd(`SRM_OFF_POOL, 32'h6);
        run(32'h0, 16'h0, 1'b1, `SRM_OP_RELEASE_RS, `SRM_ST_SUCCESS);
        run(32'h0, 16'ha, 1'b0, `SRM_OP_ALLOCATE, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_CPL0, 32'h6);
        run(32'h2, 16'h8, 1'b0, `SRM_OP_ALLOCATE, `SRM_ST_ALLOC_FAIL);
        run(32'h0, 16'h0, 1'b1, `SRM_OP_RELEASE_RS, `SRM_ST_SUCCESS);
        run(32'h2, 16'h0, 1'b0, `SRM_OP_ALLOCATE, `SRM_ST_SUCCESS);
        rd(`SRM_OFF_CPL0, 32'h0);
    endtask
    task automatic t_irq();
        wr(`SRM_OFF_IRQ_MASK, 32'h0);
        wr(`SRM_OFF_IRQ_STAT, 32'h3);
        run(32'h0, 16'h0, 1'b0, 8'h07, `SRM_ST_INVALID);
        run(32'h5, 16'h0, 1'b0, `SRM_OP_GET_STATUS, `SRM_ST_INVALID);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        host.xfer(1'b0, {20'h0, `SRM_OFF_IRQ_STAT}, 32'h0, rv);
        chk("error bit", 32'h1, {31'h0, rv[`SRM_IRQ_ERR_BIT]});
        wr(`SRM_OFF_IRQ_MASK, 32'h2);
        @(posedge clk_i);
        chk("irq raised", 32'h1, {31'h0, irq_o});
        wr(`SRM_OFF_IRQ_STAT, 32'h3);
        @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        rd(`SRM_OFF_IRQ_STAT, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_status();
        t_release_id();
        t_allocate();
        t_release_all();
        t_irq();
        stop_test();
    end
endmodule
